// >>> acclsu_params.svh
// constants for the accumulator load and store unit
`ifndef ACCLSU_PARAMS_SVH
`define ACCLSU_PARAMS_SVH

`define ACCLSU_OP_WORD_LOAD 4'h0
`define ACCLSU_OP_WORD_STORE 4'h1
`define ACCLSU_OP_BYTE_LOAD 4'h2
`define ACCLSU_OP_BYTE_STORE 4'h3
`define ACCLSU_OP_HNIB_LOAD 4'h4
`define ACCLSU_OP_HNIB_STORE 4'h5
`define ACCLSU_OP_LNIB_LOAD 4'h6
`define ACCLSU_OP_LNIB_STORE 4'h7
`define ACCLSU_OP_IMG_LOAD 4'h8
`define ACCLSU_OP_IMG_STORE 4'h9

`define ACCLSU_SRC_BYTES 2'h0
`define ACCLSU_SRC_WORD 2'h1
`define ACCLSU_SRC_CONST 2'h2

`define ACCLSU_PAIR_STEP 9'h001
`define ACCLSU_IMG_STEP 9'h008

`define ACCLSU_ST_IDLE 6'h01
`define ACCLSU_ST_RD_A 6'h02
`define ACCLSU_ST_RD_B 6'h04
`define ACCLSU_ST_RD_C 6'h08
`define ACCLSU_ST_WR_A 6'h10
`define ACCLSU_ST_WR_B 6'h20

`define ACCLSU_ACC_RESET 16'h0000

`endif

// >>> acclsu_pkg.sv
// types shared by the accumulator load and store unit
`include "acclsu_params.svh"
package acclsu_pkg;

  typedef logic [3:0] acclsu_op_t;
  typedef logic [1:0] acclsu_src_t;
  typedef logic [8:0] acclsu_addr_t;

  typedef enum logic [5:0] {
    ACCLSU_IDLE = `ACCLSU_ST_IDLE,
    ACCLSU_RD_A = `ACCLSU_ST_RD_A,
    ACCLSU_RD_B = `ACCLSU_ST_RD_B,
    ACCLSU_RD_C = `ACCLSU_ST_RD_C,
    ACCLSU_WR_A = `ACCLSU_ST_WR_A,
    ACCLSU_WR_B = `ACCLSU_ST_WR_B
  } acclsu_state_t;

  typedef struct packed {
    acclsu_op_t op;
    acclsu_src_t src;
    acclsu_addr_t addr;
    logic [15:0] konst;
  } acclsu_cmd_t;

  typedef struct packed {
    logic en;
    logic we;
    logic word;
    acclsu_addr_t addr;
    logic [15:0] wdata;
  } acclsu_mem_req_t;

  typedef struct packed {
    acclsu_state_t st;
    acclsu_op_t op;
    acclsu_src_t src;
    acclsu_addr_t addr;
    logic [15:0] acc;
    logic [7:0] lo;
    acclsu_mem_req_t req;
    logic ready;
    logic done;
    logic err;
  } acclsu_regs_t;

endpackage : acclsu_pkg

// >>> acclsu_shape.sv
// shapes loaded words and read-modify-write bytes
`timescale 1ns/1ps
`default_nettype none
`include "acclsu_params.svh"
module acclsu_shape
  import acclsu_pkg::*;
(
  input wire acclsu_op_t op_in,
  input wire acclsu_src_t src_in,
  input wire logic [15:0] acc_in,
  input wire logic [7:0] lo_in,
  input wire logic [15:0] rdata_in,
  output logic [15:0] load_val_out,
  output logic [7:0] rmw_byte_out
);

  function automatic logic [7:0] merge_nibble(input logic [7:0] old, input logic [3:0] nib, input logic upper);
    merge_nibble = upper ? {nib, old[3:0]} : {old[7:4], nib};
  endfunction : merge_nibble

  always_comb begin
    load_val_out = 16'h0000;
    case (op_in)
      `ACCLSU_OP_WORD_LOAD: begin
        load_val_out = (src_in == `ACCLSU_SRC_WORD) ? rdata_in : {rdata_in[7:0], lo_in};
      end
      `ACCLSU_OP_IMG_LOAD: load_val_out = {rdata_in[7:0], lo_in};
      `ACCLSU_OP_BYTE_LOAD: load_val_out = {8'h00, rdata_in[7:0]};
      `ACCLSU_OP_HNIB_LOAD: load_val_out = {12'h000, rdata_in[7:4]};
      `ACCLSU_OP_LNIB_LOAD: load_val_out = {12'h000, rdata_in[3:0]};
      default: load_val_out = 16'h0000;
    endcase
  end

  always_comb begin
    rmw_byte_out = rdata_in[7:0];
    case (op_in)
      `ACCLSU_OP_HNIB_STORE: rmw_byte_out = merge_nibble(rdata_in[7:0], acc_in[3:0], 1'b1);
      `ACCLSU_OP_LNIB_STORE: rmw_byte_out = merge_nibble(rdata_in[7:0], acc_in[3:0], 1'b0);
      default: rmw_byte_out = rdata_in[7:0];
    endcase
  end

endmodule : acclsu_shape
`default_nettype wire

// >>> acclsu_top.sv
// accumulator load and store sequencer with memory port
`timescale 1ns/1ps
`default_nettype none
`include "acclsu_params.svh"
module acclsu_top
  import acclsu_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic cmd_valid_in,
  input wire acclsu_cmd_t cmd_in,
  output logic cmd_ready_out,
  output logic done_out,
  output logic err_out,
  output logic [15:0] acc_out,
  output var acclsu_mem_req_t mem_req_out,
  input wire logic [15:0] mem_rdata_in
);

  acclsu_regs_t r;
  acclsu_regs_t nxt;
  logic [15:0] load_val;
  logic [7:0] rmw_byte;

  // second register of a two-register operand
  function automatic acclsu_addr_t hi_addr(input acclsu_op_t op, input acclsu_addr_t base);
    if (op == `ACCLSU_OP_IMG_LOAD || op == `ACCLSU_OP_IMG_STORE) begin
      hi_addr = base + `ACCLSU_IMG_STEP;
    end else begin
      hi_addr = base + `ACCLSU_PAIR_STEP;
    end
  endfunction : hi_addr

  // two byte registers make up the operand
  function automatic logic is_pair(input acclsu_op_t op, input acclsu_src_t src);
    is_pair = ((op == `ACCLSU_OP_WORD_LOAD || op == `ACCLSU_OP_WORD_STORE) && src == `ACCLSU_SRC_BYTES)
      || op == `ACCLSU_OP_IMG_LOAD || op == `ACCLSU_OP_IMG_STORE;
  endfunction : is_pair

  function automatic logic is_load(input acclsu_op_t op);
    is_load = (op == `ACCLSU_OP_WORD_LOAD) || (op == `ACCLSU_OP_BYTE_LOAD) || (op == `ACCLSU_OP_HNIB_LOAD)
      || (op == `ACCLSU_OP_LNIB_LOAD) || (op == `ACCLSU_OP_IMG_LOAD);
  endfunction : is_load

  function automatic acclsu_mem_req_t mk_req(input logic we, input logic word, input acclsu_addr_t addr,
                                             input logic [15:0] wdata);
    mk_req.en = 1'b1;
    mk_req.we = we;
    mk_req.word = word;
    mk_req.addr = addr;
    mk_req.wdata = wdata;
  endfunction : mk_req

  acclsu_shape acclsu_shape_inst (
    .op_in(r.op),
    .src_in(r.src),
    .acc_in(r.acc),
    .lo_in(r.lo),
    .rdata_in(mem_rdata_in),
    .load_val_out(load_val),
    .rmw_byte_out(rmw_byte)
  );

  always_comb begin
    nxt = r;
    nxt.done = 1'b0;
    nxt.err = 1'b0;
    nxt.req = '0;
    case (r.st)
      ACCLSU_IDLE: begin
        nxt.ready = 1'b1;
        if (cmd_valid_in && r.ready) begin
          nxt.op = cmd_in.op;
          nxt.src = cmd_in.src;
          nxt.addr = cmd_in.addr;
          nxt.ready = 1'b0;
          case (cmd_in.op)
            `ACCLSU_OP_WORD_LOAD: begin
              if (cmd_in.src == `ACCLSU_SRC_CONST) begin
                nxt.acc = cmd_in.konst;
                nxt.done = 1'b1;
                nxt.ready = 1'b1;
              end else if (cmd_in.src == `ACCLSU_SRC_WORD) begin
                nxt.req = mk_req(1'b0, 1'b1, cmd_in.addr, 16'h0000);
                nxt.st = ACCLSU_RD_A;
              end else if (cmd_in.src == `ACCLSU_SRC_BYTES) begin
                nxt.req = mk_req(1'b0, 1'b0, cmd_in.addr, 16'h0000);
                nxt.st = ACCLSU_RD_A;
              end else begin
                nxt.err = 1'b1;
                nxt.done = 1'b1;
                nxt.ready = 1'b1;
              end
            end
            `ACCLSU_OP_WORD_STORE: begin
              if (cmd_in.src == `ACCLSU_SRC_WORD) begin
                nxt.req = mk_req(1'b1, 1'b1, cmd_in.addr, r.acc);
                nxt.st = ACCLSU_WR_A;
              end else if (cmd_in.src == `ACCLSU_SRC_BYTES) begin
                nxt.req = mk_req(1'b1, 1'b0, cmd_in.addr, {8'h00, r.acc[7:0]});
                nxt.st = ACCLSU_WR_A;
              end else begin
                nxt.err = 1'b1;
                nxt.done = 1'b1;
                nxt.ready = 1'b1;
              end
            end
            `ACCLSU_OP_BYTE_STORE: begin
              nxt.req = mk_req(1'b1, 1'b0, cmd_in.addr, {8'h00, r.acc[7:0]});
              nxt.st = ACCLSU_WR_A;
            end
            `ACCLSU_OP_IMG_STORE: begin
              nxt.req = mk_req(1'b1, 1'b0, cmd_in.addr, {8'h00, r.acc[7:0]});
              nxt.st = ACCLSU_WR_A;
            end
            `ACCLSU_OP_BYTE_LOAD,
            `ACCLSU_OP_HNIB_LOAD,
            `ACCLSU_OP_LNIB_LOAD,
            `ACCLSU_OP_IMG_LOAD,
            `ACCLSU_OP_HNIB_STORE,
            `ACCLSU_OP_LNIB_STORE: begin
              // nibble stores read first so the other half survives
              nxt.req = mk_req(1'b0, 1'b0, cmd_in.addr, 16'h0000);
              nxt.st = ACCLSU_RD_A;
            end
            default: begin
              nxt.err = 1'b1;
              nxt.done = 1'b1;
              nxt.ready = 1'b1;
            end
          endcase
        end
      end
      ACCLSU_RD_A: begin
        if (is_pair(r.op, r.src)) begin
          nxt.req = mk_req(1'b0, 1'b0, hi_addr(r.op, r.addr), 16'h0000);
        end
        nxt.st = ACCLSU_RD_B;
      end
      ACCLSU_RD_B: begin
        nxt.lo = mem_rdata_in[7:0];
        if (is_pair(r.op, r.src)) begin
          nxt.st = ACCLSU_RD_C;
        end else if (is_load(r.op)) begin
          nxt.acc = load_val;
          nxt.st = ACCLSU_IDLE;
          nxt.done = 1'b1;
          nxt.ready = 1'b1;
        end else begin
          nxt.req = mk_req(1'b1, 1'b0, r.addr, {8'h00, rmw_byte});
          nxt.st = ACCLSU_WR_A;
        end
      end
      ACCLSU_RD_C: begin
        nxt.acc = load_val;
        nxt.st = ACCLSU_IDLE;
        nxt.done = 1'b1;
        nxt.ready = 1'b1;
      end
      ACCLSU_WR_A: begin
        if (is_pair(r.op, r.src)) begin
          nxt.req = mk_req(1'b1, 1'b0, hi_addr(r.op, r.addr), {8'h00, r.acc[15:8]});
          nxt.st = ACCLSU_WR_B;
        end else begin
          nxt.st = ACCLSU_IDLE;
          nxt.done = 1'b1;
          nxt.ready = 1'b1;
        end
      end
      ACCLSU_WR_B: begin
        nxt.st = ACCLSU_IDLE;
        nxt.done = 1'b1;
        nxt.ready = 1'b1;
      end
      default: begin
        nxt.st = ACCLSU_IDLE;
        nxt.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      r.st <= ACCLSU_IDLE;
      r.op <= `ACCLSU_OP_WORD_LOAD;
      r.src <= `ACCLSU_SRC_BYTES;
      r.addr <= 9'h000;
      r.acc <= `ACCLSU_ACC_RESET;
      r.lo <= 8'h00;
      r.req <= '0;
      r.ready <= 1'b1;
      r.done <= 1'b0;
      r.err <= 1'b0;
    end else begin
      r <= nxt;
    end
  end

  // stores never touch the accumulator, so it is stable across them
  assign acc_out = r.acc;
  assign mem_req_out = r.req;
  assign cmd_ready_out = r.ready;
  assign done_out = r.done;
  assign err_out = r.err;

endmodule : acclsu_top
`default_nettype wire

// >>> acclsu_props.sv
// assertions for the accumulator load and store unit
`timescale 1ns/1ps
`default_nettype none
`include "acclsu_params.svh"
module acclsu_props
  import acclsu_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic cmd_valid_in,
  input wire acclsu_cmd_t cmd_in,
  input wire logic cmd_ready_out,
  input wire logic done_out,
  input wire logic err_out,
  input wire logic [15:0] acc_out,
  input wire acclsu_mem_req_t mem_req_out,
  input wire logic [15:0] mem_rdata_in
);
  acclsu_op_t op_r;
  acclsu_src_t src_r;
  logic [15:0] rd_r;
  logic [7:0] rd2_r;
  logic take;
  logic wr;
  logic pair;
  assign take = cmd_valid_in && cmd_ready_out;
  assign wr = mem_req_out.en && mem_req_out.we;
  // image codes carry bit 3, word codes are 0 and 1; refused codes never touch memory
  assign pair = op_r[3] || (op_r[3:1] == 3'h0 && src_r == `ACCLSU_SRC_BYTES);
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      op_r <= 4'h0;
      src_r <= 2'h0;
      rd_r <= 16'h0000;
      rd2_r <= 8'h00;
    end else begin
      rd_r <= mem_rdata_in;
      rd2_r <= rd_r[7:0];
      if (take) begin
        op_r <= cmd_in.op;
        src_r <= cmd_in.src;
      end
    end
  end
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!arst_n_in);
  a_const_load: assert property (take && cmd_in.op == `ACCLSU_OP_WORD_LOAD && cmd_in.src == `ACCLSU_SRC_CONST
    |=> done_out && acc_out == $past(cmd_in.konst)) else $error("constant load wrong");
  a_const_dest: assert property (take && cmd_in.op == `ACCLSU_OP_WORD_STORE && cmd_in.src == `ACCLSU_SRC_CONST
    |=> done_out && err_out && !mem_req_out.en && $stable(acc_out)) else $error("constant target taken");
  a_byte_load: assert property (done_out && !err_out && op_r == `ACCLSU_OP_BYTE_LOAD
    |-> acc_out == {8'h00, rd_r[7:0]}) else $error("byte load wrong");
  a_byte_store: assert property (wr && op_r == `ACCLSU_OP_BYTE_STORE
    |-> !mem_req_out.word && mem_req_out.wdata == {8'h00, acc_out[7:0]}) else $error("byte store wrong");
  a_high_merge: assert property (wr && op_r == `ACCLSU_OP_HNIB_STORE
    |-> mem_req_out.wdata == {8'h00, acc_out[3:0], rd_r[3:0]}) else $error("high merge wrong");
  a_low_merge: assert property (wr && op_r == `ACCLSU_OP_LNIB_STORE
    |-> mem_req_out.wdata == {8'h00, rd_r[7:4], acc_out[3:0]}) else $error("low merge wrong");
  a_pair_addr: assert property (mem_req_out.en && !$past(mem_req_out.en) && pair
    |=> mem_req_out.en && mem_req_out.addr == $past(mem_req_out.addr) + (op_r[3] ? `ACCLSU_IMG_STEP : `ACCLSU_PAIR_STEP))
    else $error("second register wrong");
  a_pair_data: assert property (done_out && !err_out && pair && !op_r[0]
    |-> acc_out == {rd_r[7:0], rd2_r}) else $error("pair load wrong");
  c_refused: cover property (done_out && err_out);
  c_merge: cover property (wr && op_r == `ACCLSU_OP_HNIB_STORE);
  c_pair: cover property (done_out && pair);
endmodule : acclsu_props
bind acclsu_top acclsu_props acclsu_props_inst (.sys_clk_in, .arst_n_in, .cmd_valid_in, .cmd_in, .cmd_ready_out,
  .done_out, .err_out, .acc_out, .mem_req_out, .mem_rdata_in);
`default_nettype wire

// >>> acclsu_bench.sv
// self-checking bench for the accumulator load and store unit
`timescale 1ns/1ps
`default_nettype none
`include "acclsu_params.svh"
module acclsu_bench;
  import acclsu_pkg::*;
  logic sys_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  acclsu_cmd_t cmd_in = '0;
  logic cmd_ready_out;
  logic done_out;
  logic err_out;
  logic [15:0] acc_out;
  logic [15:0] mem_rdata_in = 16'h0000;
  acclsu_mem_req_t m;
  logic [7:0] b [512];
  logic [15:0] w [512];
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  always #20 sys_clk_in = ~sys_clk_in;
  acclsu_top acclsu_top_inst (.sys_clk_in, .arst_n_in, .cmd_valid_in, .cmd_in, .cmd_ready_out,
    .done_out, .err_out, .acc_out, .mem_req_out(m), .mem_rdata_in);
  // ceiling far above the fewer than a hundred cycles the scenarios need
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      bad_count++;
      final_report();
    end
  end
  // idle cycles show inverted data, byte reads junk upper bits, so sloppy sampling fails
  always @(posedge sys_clk_in) begin
    if (m.en && !m.we)
      mem_rdata_in <= m.word ? w[m.addr] : {~b[m.addr], b[m.addr]};
    else
      mem_rdata_in <= ~mem_rdata_in;
    if (m.en && m.we && m.word)
      w[m.addr] <= m.wdata;
    if (m.en && m.we && !m.word)
      b[m.addr] <= m.wdata[7:0];
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // returns with the done cycle still visible for the caller
  task automatic op(input acclsu_op_t o, input acclsu_src_t s, input acclsu_addr_t a,
    input logic [15:0] k, input int n, input logic e);
    int i;
    cmd_valid_in <= 1'b1;
    cmd_in <= {o, s, a, k};
    @(posedge sys_clk_in);
    cmd_valid_in <= 1'b0;
    for (i = 0; i < 9 && done_out !== 1'b1; i++) begin
      @(posedge sys_clk_in);
    end
    // done first seen after edge i of the take counts as cycle i
    chk(16'(i), 16'(n));
    chk({15'h0000, err_out}, {15'h0000, e});
  endtask : op
  task automatic t_word();
    op(`ACCLSU_OP_WORD_LOAD, `ACCLSU_SRC_BYTES, 9'h102, 16'h0000, 4, 1'b0);
    chk(acc_out, 16'h7502);
    op(`ACCLSU_OP_WORD_LOAD, `ACCLSU_SRC_WORD, 9'h180, 16'h0000, 3, 1'b0);
    chk(acc_out, 16'h1234);
    op(`ACCLSU_OP_WORD_LOAD, `ACCLSU_SRC_CONST, 9'h000, 16'h4107, 1, 1'b0);
    chk(acc_out, 16'h4107);
  endtask : t_word
  task automatic t_store();
    op(`ACCLSU_OP_WORD_STORE, `ACCLSU_SRC_CONST, 9'h000, 16'h0000, 1, 1'b1);
    op(`ACCLSU_OP_WORD_STORE, 2'h3, 9'h000, 16'h0000, 1, 1'b1);
    op(4'hA, 2'h0, 9'h000, 16'h0000, 1, 1'b1);
    op(`ACCLSU_OP_WORD_LOAD, 2'h3, 9'h000, 16'h0000, 1, 1'b1);
    op(`ACCLSU_OP_WORD_STORE, `ACCLSU_SRC_BYTES, 9'h104, 16'h0000, 3, 1'b0);
    chk({b[9'h105], b[9'h104]}, 16'h4107);
    op(`ACCLSU_OP_WORD_STORE, `ACCLSU_SRC_WORD, 9'h181, 16'h0000, 2, 1'b0);
    chk(w[9'h181], 16'h4107);
    chk(acc_out, 16'h4107);
  endtask : t_store
  task automatic t_byte();
    op(`ACCLSU_OP_WORD_LOAD, `ACCLSU_SRC_CONST, 9'h000, 16'hABCD, 1, 1'b0);
    op(`ACCLSU_OP_BYTE_STORE, 2'h0, 9'h140, 16'h0000, 2, 1'b0);
    chk({8'h00, b[9'h140]}, 16'h00CD);
    op(`ACCLSU_OP_BYTE_LOAD, 2'h0, 9'h108, 16'h0000, 3, 1'b0);
    chk(acc_out, 16'h0089);
  endtask : t_byte
  task automatic t_nib();
    op(`ACCLSU_OP_HNIB_LOAD, 2'h0, 9'h001, 16'h0000, 3, 1'b0);
    chk(acc_out, 16'h000A);
    op(`ACCLSU_OP_LNIB_LOAD, 2'h0, 9'h001, 16'h0000, 3, 1'b0);
    chk(acc_out, 16'h0005);
    op(`ACCLSU_OP_LNIB_STORE, 2'h0, 9'h00E, 16'h0000, 4, 1'b0);
    chk({8'h00, b[9'h00E]}, 16'h00C5);
    op(`ACCLSU_OP_HNIB_STORE, 2'h0, 9'h100, 16'h0000, 4, 1'b0);
    chk({8'h00, b[9'h100]}, 16'h005C);
  endtask : t_nib
  task automatic t_img();
    op(`ACCLSU_OP_IMG_LOAD, 2'h0, 9'h000, 16'h0000, 4, 1'b0);
    chk(acc_out, 16'h2211);
    op(`ACCLSU_OP_IMG_STORE, 2'h0, 9'h001, 16'h0000, 3, 1'b0);
    chk({b[9'h009], b[9'h001]}, 16'h2211);
  endtask : t_img
  // a command offered while busy is dropped, not queued
  task automatic t_busy();
    cmd_valid_in <= 1'b1;
    cmd_in <= {`ACCLSU_OP_BYTE_LOAD, 2'h0, 9'h108, 16'h0000};
    @(posedge sys_clk_in);
    cmd_in <= {`ACCLSU_OP_WORD_LOAD, `ACCLSU_SRC_CONST, 9'h000, 16'h1111};
    @(posedge sys_clk_in);
    cmd_valid_in <= 1'b0;
    chk({15'h0000, cmd_ready_out}, 16'h0000);
    repeat (4) @(posedge sys_clk_in);
    chk(acc_out, 16'h0089);
  endtask : t_busy
  initial begin
    b[9'h102] = 8'h02;
    b[9'h103] = 8'h75;
    w[9'h180] = 16'h1234;
    b[9'h108] = 8'h89;
    b[9'h001] = 8'hA5;
    b[9'h00E] = 8'hCA;
    b[9'h100] = 8'h3C;
    b[9'h000] = 8'h11;
    b[9'h008] = 8'h22;
    repeat (8) @(posedge sys_clk_in);
    arst_n_in <= 1'b1;
    t_word();
    t_store();
    t_byte();
    t_nib();
    t_img();
    t_busy();
    final_report();
  end
endmodule : acclsu_bench
`default_nettype wire
